// file: rtl/can_node_status_image.sv
// Read-only CAN node status image with error counter logic
// How it works
// - Sixteen-byte input image; output image ignored
// - Byte 0 module status; bits 6,4..1 zero
// - Bit 0 set once configured and ready
// - Bit 5 always one, slave variant
// - Bit 7 set on any error flag
// - Byte 1 mirrors controller error flags
// - Byte 2 send/receive FIFO status nibbles
// - Bytes 3,4 transmit and receive counts
// - Byte 5 slave state code
// - Bytes 6,7 heartbeat watched node states
// - Heartbeat codes plus 7E for unknown
// - Byte 8 node id; 9..15 internal
// - Count up on error, down on success
// - Transmit passive while count at least 128
// - Receive passive while count at least 128
// - Warning flags while count at least 96
// - Warning state from 96 count
// - Passive state above 127 count
module can_node_status_image #(
    parameter int RECOVERY = status_image_pkg::RECOVERY_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Host image access
    input wire logic [3:0] in_addr_i,
    output logic [7:0] in_data_o,
    input wire logic out_we_i,
    input wire logic [3:0] out_addr_i,
    input wire logic [7:0] out_data_i,
    // Module and CANopen state
    input wire logic config_done_i,
    input wire logic [1:0] slave_state_i,
    input wire logic [7:0] node_id_i,
    input wire logic [7:0] hb_one_state_i,
    input wire logic [7:0] hb_two_state_i,
    input wire logic [7:0] internal_data_i [7],
    // CAN frame events
    input wire logic tx_error_i,
    input wire logic tx_ok_i,
    input wire logic rx_error_i,
    input wire logic rx_ok_i,
    input wire logic recovery_ok_i,
    input wire logic rx0_valid_i,
    input wire logic rx0_full_i,
    input wire logic rx1_valid_i,
    input wire logic rx1_full_i,
    input wire logic rx0_ovr_clear_i,
    input wire logic rx1_ovr_clear_i,
    // FIFO status nibbles
    input wire logic [3:0] send_fifo_i,
    input wire logic [3:0] recv_fifo_i,
    // Controller status
    output logic [7:0] error_flags_o
);
    localparam logic [7:0] RECOVERY_W = 8'(RECOVERY - 1);

    image_bus_if bus ();

    // Host output image writes are deliberately unconnected
    logic out_unused;
    assign out_unused = out_we_i ^ (|out_addr_i) ^ (|out_data_i);

    function automatic logic [7:0] state_code(input logic [1:0] s);
        case (s)
            2'h0: state_code = status_image_pkg::CODE_BOOTUP;
            2'h1: state_code = status_image_pkg::CODE_STOPPED;
            2'h2: state_code = status_image_pkg::CODE_OPERATIONAL;
            default: state_code = status_image_pkg::CODE_PREOP;
        endcase
    endfunction

    // Heartbeat byte only passes legal codes; else unknown
    function automatic logic [7:0] hb_code(input logic [7:0] v);
        if (v == status_image_pkg::CODE_BOOTUP ||
            v == status_image_pkg::CODE_STOPPED ||
            v == status_image_pkg::CODE_OPERATIONAL ||
            v == status_image_pkg::CODE_PREOP) begin
            hb_code = v;
        end else begin
            hb_code = status_image_pkg::CODE_UNKNOWN;
        end
    endfunction

    // Counters are 9 bits so the bus-off limit is reachable
    logic [8:0] tec_r, tec_nxt, rec_r, rec_nxt;
    logic bus_off_r, bus_off_nxt;
    logic [7:0] recov_r, recov_nxt;
    logic ovr0_r, ovr0_nxt, ovr1_r, ovr1_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [3:0] wptr_r, wptr_nxt;
    logic [7:0] wbyte;
    logic [7:0] flags_o_r;

    always_comb begin
        tec_nxt = tec_r;
        rec_nxt = rec_r;
        bus_off_nxt = bus_off_r;
        recov_nxt = recov_r;
        if (bus_off_r) begin
            // Counting restarts only after recovery completes
            if (recov_r != 8'h00) begin
                recov_nxt = recov_r - 8'h01;
            end else if (recovery_ok_i) begin
                bus_off_nxt = 1'b0;
                tec_nxt = status_image_pkg::COUNT_RESET;
                rec_nxt = status_image_pkg::COUNT_RESET;
            end
        end else begin
            if (tx_error_i) begin
                tec_nxt = tec_r + 9'h001;
            end else if (tx_ok_i && tec_r != 9'h000) begin
                tec_nxt = tec_r - 9'h001;
            end
            if (rx_error_i && rec_r != 9'h0FF) begin
                rec_nxt = rec_r + 9'h001;
            end else if (rx_ok_i && rec_r != 9'h000) begin
                rec_nxt = rec_r - 9'h001;
            end
            if (tec_nxt >= status_image_pkg::BUS_OFF_LIMIT) begin
                bus_off_nxt = 1'b1;
                recov_nxt = RECOVERY_W;
            end
        end
        // Set wins over host clear
        ovr0_nxt = (rx0_valid_i && rx0_full_i) ||
                   (ovr0_r && !rx0_ovr_clear_i);
        ovr1_nxt = (rx1_valid_i && rx1_full_i) ||
                   (ovr1_r && !rx1_ovr_clear_i);
    end

    always_comb begin
        flags_nxt = 8'h00;
        flags_nxt[status_image_pkg::EF_RX1_OVR_BIT] = ovr1_r;
        flags_nxt[status_image_pkg::EF_RX0_OVR_BIT] = ovr0_r;
        flags_nxt[status_image_pkg::EF_BUS_OFF_BIT] = bus_off_r;
        flags_nxt[status_image_pkg::EF_TX_PASSIVE_BIT] =
            tec_r >= status_image_pkg::PASSIVE_LIMIT;
        flags_nxt[status_image_pkg::EF_RX_PASSIVE_BIT] =
            rec_r >= status_image_pkg::PASSIVE_LIMIT;
        flags_nxt[status_image_pkg::EF_TX_WARN_BIT] =
            tec_r >= status_image_pkg::WARN_LIMIT;
        flags_nxt[status_image_pkg::EF_RX_WARN_BIT] =
            rec_r >= status_image_pkg::WARN_LIMIT;
        flags_nxt[status_image_pkg::EF_ANY_WARN_BIT] =
            flags_nxt[status_image_pkg::EF_TX_WARN_BIT] |
            flags_nxt[status_image_pkg::EF_RX_WARN_BIT];
    end

    // Image refresh walks all 16 bytes, one per cycle
    always_comb begin
        wptr_nxt = wptr_r + 4'h1;
        wbyte = 8'h00;
        case (wptr_r)
            status_image_pkg::OFS_MODULE_STATUS: begin
                wbyte[status_image_pkg::MS_READY_BIT] =
                    config_done_i;
                wbyte[status_image_pkg::MS_SLAVE_ID_BIT] = 1'b1;
                wbyte[status_image_pkg::MS_GROUP_ERR_BIT] =
                    |flags_r;
            end
            status_image_pkg::OFS_CONTROLLER_ERROR_FLAGS:
                wbyte = flags_r;
            status_image_pkg::OFS_FIFO_STATE:
                wbyte = {send_fifo_i, recv_fifo_i};
            status_image_pkg::OFS_TRANSMIT_ERROR_COUNT:
                wbyte = tec_r[8] ? 8'hFF : tec_r[7:0];
            status_image_pkg::OFS_RECEIVE_ERROR_COUNT:
                wbyte = rec_r[7:0];
            status_image_pkg::OFS_SLAVE_STATE:
                wbyte = state_code(slave_state_i);
            status_image_pkg::OFS_HEARTBEAT_WATCH_ONE:
                wbyte = hb_code(hb_one_state_i);
            status_image_pkg::OFS_HEARTBEAT_WATCH_TWO:
                wbyte = hb_code(hb_two_state_i);
            status_image_pkg::OFS_ACTIVE_NODE_NUMBER:
                wbyte = node_id_i;
            default:
                wbyte = internal_data_i[3'(wptr_r - 4'h9)];
        endcase
    end

    assign bus.we = 1'b1;
    assign bus.waddr = wptr_r;
    assign bus.wdata = wbyte;
    assign bus.raddr = in_addr_i;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tec_r <= status_image_pkg::COUNT_RESET;
            rec_r <= status_image_pkg::COUNT_RESET;
            bus_off_r <= 1'b0;
            recov_r <= 8'h00;
            ovr0_r <= 1'b0;
            ovr1_r <= 1'b0;
            flags_r <= status_image_pkg::BYTE_RESET;
            flags_o_r <= status_image_pkg::BYTE_RESET;
            wptr_r <= 4'h0;
        end else begin
            tec_r <= tec_nxt;
            rec_r <= rec_nxt;
            bus_off_r <= bus_off_nxt;
            recov_r <= recov_nxt;
            ovr0_r <= ovr0_nxt;
            ovr1_r <= ovr1_nxt;
            flags_r <= flags_nxt;
            flags_o_r <= flags_nxt;
            wptr_r <= wptr_nxt;
        end
    end

    image_mem #(
        .DEPTH(status_image_pkg::IMAGE_BYTES)
    ) u_mem (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .bus(bus)
    );

    assign in_data_o = bus.rdata;
    assign error_flags_o = flags_o_r;

    // Checks
    tx_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !bus_off_r && tx_error_i && tec_r < 9'h0FF
        |=> tec_r == $past(tec_r) + 9'h001)
        else $error("tx count not incremented");
    tx_down_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !bus_off_r && !tx_error_i && tx_ok_i && tec_r != 9'h000
        |=> tec_r == $past(tec_r) - 9'h001)
        else $error("tx count not decremented");
    tx_passive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ##1 flags_r[4] == ($past(tec_r) >= 9'h080))
        else $error("tx passive flag wrong");
    rx_passive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ##1 flags_r[3] == ($past(rec_r) >= 9'h080))
        else $error("rx passive flag wrong");
    warn_flags_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ##1 flags_r[2] == ($past(tec_r) >= 9'h060) &&
        flags_r[1] == ($past(rec_r) >= 9'h060))
        else $error("warning flags wrong");
    any_warn_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        flags_r[0] == (flags_r[2] | flags_r[1]))
        else $error("any warning not OR");
    // Release only after the hold-off count and a finished recovery
    bus_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(bus_off_r) |-> $past(recov_r) == 8'h00 && $past(recovery_ok_i))
        else $error("bus off released early");
    overflow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        rx0_valid_i && rx0_full_i |=> ovr0_r)
        else $error("overflow not set");
    status_byte_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wptr_r == 4'h0 |-> wbyte[6] == 1'b0 && wbyte[4:1] == 4'h0 &&
        wbyte[5] && wbyte[7] == |flags_r)
        else $error("status byte wrong");
    read_lat_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        in_addr_i == status_image_pkg::OFS_MODULE_STATUS
        |=> (in_data_o & 8'h5E) == 8'h00)
        else $error("reserved status bits read set");
    busoff_cv: cover property (@(posedge ref_clk_i) $rose(bus_off_r));
    recover_cv: cover property (@(posedge ref_clk_i) $fell(bus_off_r));
    passive_cv: cover property (@(posedge ref_clk_i) $rose(flags_r[4]));
    ovr_cv: cover property (@(posedge ref_clk_i) ovr1_r && rx1_ovr_clear_i);
endmodule // can_node_status_image

// file: inc/status_image_pkg.sv
// Package: image offsets, field positions, codes and limits
package status_image_pkg;
    localparam int IMAGE_BYTES = 16;
    localparam logic [3:0] OFS_MODULE_STATUS = 4'h0;
    localparam logic [3:0] OFS_CONTROLLER_ERROR_FLAGS = 4'h1;
    localparam logic [3:0] OFS_FIFO_STATE = 4'h2;
    localparam logic [3:0] OFS_TRANSMIT_ERROR_COUNT = 4'h3;
    localparam logic [3:0] OFS_RECEIVE_ERROR_COUNT = 4'h4;
    localparam logic [3:0] OFS_SLAVE_STATE = 4'h5;
    localparam logic [3:0] OFS_HEARTBEAT_WATCH_ONE = 4'h6;
    localparam logic [3:0] OFS_HEARTBEAT_WATCH_TWO = 4'h7;
    localparam logic [3:0] OFS_ACTIVE_NODE_NUMBER = 4'h8;
    // Module status bits
    localparam int MS_READY_BIT = 0;
    localparam int MS_SLAVE_ID_BIT = 5;
    localparam int MS_GROUP_ERR_BIT = 7;
    // Error flag bits
    localparam int EF_RX1_OVR_BIT = 7;
    localparam int EF_RX0_OVR_BIT = 6;
    localparam int EF_BUS_OFF_BIT = 5;
    localparam int EF_TX_PASSIVE_BIT = 4;
    localparam int EF_RX_PASSIVE_BIT = 3;
    localparam int EF_TX_WARN_BIT = 2;
    localparam int EF_RX_WARN_BIT = 1;
    localparam int EF_ANY_WARN_BIT = 0;
    // Counter limits
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
    localparam logic [8:0] COUNT_RESET = 9'h000;
    localparam int RECOVERY_CYCLES = 128;
    // Slave state codes
    localparam logic [7:0] CODE_BOOTUP = 8'h00;
    localparam logic [7:0] CODE_STOPPED = 8'h04;
    localparam logic [7:0] CODE_OPERATIONAL = 8'h05;
    localparam logic [7:0] CODE_UNKNOWN = 8'h7E;
    localparam logic [7:0] CODE_PREOP = 8'h7F;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    typedef enum logic [1:0] {
        ST_BOOTUP, ST_STOPPED, ST_OPERATIONAL, ST_PREOP
    } slave_state_t;
endpackage

// file: inc/image_bus_if.sv
// Interface: image write and read port between top and image memory
interface image_bus_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport writer (output we, output waddr, output wdata,
                    output raddr, input rdata);
    modport mem (input we, input waddr, input wdata,
                 input raddr, output rdata);
endinterface

// file: rtl/image_mem.sv
// Small image memory with registered read data
module image_mem #(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    image_bus_if.mem bus
);
    logic [7:0] mem_r [DEPTH];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = mem_r[bus.raddr];
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= status_image_pkg::BYTE_RESET;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= status_image_pkg::BYTE_RESET;
            end
        end else begin
            rdata_r <= rdata_nxt;
            if (bus.we) begin
                mem_r[bus.waddr] <= bus.wdata;
            end
        end
    end

    assign bus.rdata = rdata_r;
endmodule // image_mem

// file: sim/image_host_model.sv
// Host model: reads status image bytes over the backplane port
module image_host_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Requests from the bench
    input wire logic rd_req_i,
    input wire logic [3:0] rd_addr_i,
    // Image port of the device
    output logic [3:0] in_addr_o,
    input wire logic [7:0] in_data_i,
    // Read results
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic p1_r;
    logic p2_r;
    // Address held one cycle, data taken one cycle after it is sampled
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_addr_o <= 4'h0;
            p1_r <= 1'b0;
            p2_r <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else begin
            in_addr_o <= rd_addr_i;
            p1_r <= rd_req_i;
            p2_r <= p1_r;
            rsp_valid_o <= p2_r;
            rsp_data_o <= in_data_i;
        end
    end
endmodule // image_host_model

// file: sim/tb_top.sv
// Testbench for the CAN node status image
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] rd_addr = 4'h0, in_addr, out_addr = 4'h0;
    logic rd_req = 1'b0, rsp_valid, out_we = 1'b0, cfg = 1'b0, rec_ok = 1'b0;
    logic [7:0] rsp_data, in_data, eflags, node = 8'h00, out_data = 8'h00;
    logic [7:0] hb1 = 8'h00, hb2 = 8'h00;
    logic [1:0] sstate = 2'h0;
    logic [7:0] idata [7] = '{default: 8'h00};
    logic txe = 1'b0, txk = 1'b0, rxe = 1'b0, rxk = 1'b0;
    logic v0 = 1'b0, f0 = 1'b0, v1 = 1'b0, f1 = 1'b0, c0 = 1'b0, c1 = 1'b0;
    logic [3:0] sf = 4'h0, rf = 4'h0;
    logic [7:0] expq [$];
    logic [7:0] lfsr = 8'h5A;
    logic boff = 1'b0, ov0 = 1'b0, ov1 = 1'b0;
    int bad_count = 0, checks = 0, cycles = 0, tec = 0, rec = 0;
    localparam logic [7:0] CODES [4] = '{status_image_pkg::CODE_BOOTUP,
        status_image_pkg::CODE_STOPPED, status_image_pkg::CODE_OPERATIONAL,
        status_image_pkg::CODE_PREOP};

    always #25 ref_clk_i = ~ref_clk_i;

    // Short recovery keeps the bus-off scenario brief
    can_node_status_image #(.RECOVERY(4)) uut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .in_addr_i(in_addr), .in_data_o(in_data),
        .out_we_i(out_we), .out_addr_i(out_addr), .out_data_i(out_data),
        .config_done_i(cfg), .slave_state_i(sstate), .node_id_i(node),
        .hb_one_state_i(hb1), .hb_two_state_i(hb2), .internal_data_i(idata),
        .tx_error_i(txe), .tx_ok_i(txk), .rx_error_i(rxe), .rx_ok_i(rxk),
        .recovery_ok_i(rec_ok), .rx0_valid_i(v0), .rx0_full_i(f0),
        .rx1_valid_i(v1), .rx1_full_i(f1), .rx0_ovr_clear_i(c0),
        .rx1_ovr_clear_i(c1), .send_fifo_i(sf), .recv_fifo_i(rf),
        .error_flags_o(eflags));

    image_host_model host (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rd_req_i(rd_req),
        .rd_addr_i(rd_addr), .in_addr_o(in_addr), .in_data_i(in_data),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    function automatic logic [7:0] hbx(input logic [7:0] v);
        foreach (CODES[i]) if (v == CODES[i]) return v;
        return status_image_pkg::CODE_UNKNOWN;
    endfunction

    function automatic logic [7:0] flags();
        return {ov1, ov0, boff, tec >= 128, rec >= 128, tec >= 96, rec >= 96,
                tec >= 96 || rec >= 96};
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        // Notes left over mean a read never came back
        if (expq.size() != 0) bad_count++;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
        #2;
    endtask

    // Leaves the request raised so reads can run back to back
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rd_addr = a;
        rd_req = 1'b1;
        expq.push_back(e);
        tick();
    endtask

    // Waits out the round-robin refresh before reading
    task automatic check_regs();
        logic [7:0] f;
        f = flags();
        repeat (20) tick();
        cmp(eflags, f);
        rd(4'h1, f);
        rd(4'h3, tec > 255 ? 8'hFF : 8'(tec));
        rd(4'h4, 8'(rec));
        rd(4'h0, {|f, 1'b0, 1'b1, 4'h0, cfg});
        rd_req = 1'b0;
        repeat (4) tick();
    endtask

    task automatic frames(input int kind, input int n);
        repeat (n) begin
            case (kind)
                0: txe = 1'b1;
                1: txk = 1'b1;
                2: rxe = 1'b1;
                default: rxk = 1'b1;
            endcase
            tick();
            {txe, txk, rxe, rxk} = 4'h0;
            tick();
            if (!boff) begin
                case (kind)
                    0: tec++;
                    1: tec = tec > 0 ? tec - 1 : 0;
                    2: rec = rec < 255 ? rec + 1 : 255;
                    default: rec = rec > 0 ? rec - 1 : 0;
                endcase
            end
            if (tec >= 256) boff = 1'b1;
        end
    endtask

    always @(negedge ref_clk_i) begin
        if (rsp_valid === 1'b1) begin
            if (expq.size() != 0) begin
                cmp(rsp_data, expq.pop_front());
            end else begin
                bad_count++;
                $display("FAIL t=%0t got=%h exp=%h no note", $time, rsp_data,
                         8'h00);
            end
        end
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #2 resetn_i = 1'b1;
        check_regs();
        cfg = 1'b1;
        for (int s = 0; s < 4; s++) begin
            sstate = 2'(s);
            hb1 = rnd();
            hb2 = CODES[s];
            node = rnd();
            {sf, rf} = rnd();
            foreach (idata[i]) idata[i] = rnd();
            out_we = 1'b1;
            out_addr = 4'(s);
            out_data = rnd();
            tick();
            out_we = 1'b0;
            repeat (20) tick();
            rd(4'h0, 8'h21);
            rd(4'h2, {sf, rf});
            rd(4'h5, CODES[s]);
            rd(4'h6, hbx(hb1));
            rd(4'h7, CODES[s]);
            rd(4'h8, node);
            rd(4'h9 + 4'(s), idata[s]);
            rd_req = 1'b0;
            repeat (4) tick();
        end
        frames(0, 95);
        check_regs();
        frames(0, 1);
        check_regs();
        frames(0, 32);
        check_regs();
        frames(1, 1);
        check_regs();
        frames(2, 128);
        check_regs();
        frames(3, 1);
        check_regs();
        frames(0, 129);
        check_regs();
        rec_ok = 1'b1;
        repeat (2) tick();
        rec_ok = 1'b0;
        {tec, rec, boff} = 0;
        check_regs();
        v0 = 1'b1;
        tick();
        v0 = 1'b0;
        {f0, f1} = 2'h3;
        tick();
        {v0, v1, c1} = 3'h7;
        tick();
        {v0, v1, c1, f0, f1} = 5'h00;
        {ov0, ov1} = 2'h3;
        check_regs();
        // New overflow and clear together: set must win
        {v0, f0, c0, c1} = 4'hF;
        tick();
        {v0, f0, c0, c1, ov1} = 5'h00;
        check_regs();
        c0 = 1'b1;
        tick();
        {c0, ov0} = 2'h0;
        check_regs();
        // Mid-run reset with configuration withdrawn
        {resetn_i, cfg} = 2'h0;
        tick();
        resetn_i = 1'b1;
        check_regs();
        tally_and_finish();
    end
endmodule // tb_top
